// ### design/mxc_config.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// Functional notes
// - First block base comes from four base switches through a lookup table.
// - Further blocks, two per panel, follow contiguously above the first.
// - Every block base is aligned to 32 bytes.
// - Host writes the base interrupt vector; device stores it.
// - Global flow switch off disables CTS flow control on all lines.
// - Per-line flow switches: open disables, closed enables that line.
// - Flow-enabled line transmits only while its CTS input is asserted.
// - Holds caused by CTS are never visible in any register.
// - Double-stop switch forces two stop bits on every transmitted character.
// - Double-stop switch makes all receivers expect two stop bits.
// - Loopback switch forces every line into local loopback.
// - Per-adapter DSR switch makes its eight lines report DSR separately.
// - Panel numbers follow cable position; no panel address switches.
// - Two-position switch selects one to three installed panels.
// - Emulations decoded equal twice the installed panel count.
// - Each emulation occupies sixteen word registers.
// -----------------------------------------------------------------------------
module mxc_config
  import mxc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // APB register port.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Configuration switches (closed/on = 1).
  input  wire logic [3:0]              base_address_switches,
  input  wire logic [1:0]              panel_count_switches,
  input  wire logic                    global_flow_gate_switch,
  input  wire logic                    force_double_stop_switch,
  input  wire logic                    force_loopback_switch,
  input  wire logic [NUM_LINES-1:0]    per_line_flow_enable_switches,
  input  wire logic [NUM_ADAPTERS-1:0] independent_dsr_switch,
  // Host-bus address decode.
  input  wire logic [HOST_AW-1:0]      host_addr,
  input  wire logic                    host_strobe,
  // Line-side status from the character engines.
  input  wire logic [NUM_LINES-1:0]    line_cts,
  // Host decode results, per-line controls, vector and emulation count outputs.
  output logic                         host_hit,
  output logic      [2:0]              host_emul,
  output logic      [3:0]              host_reg,
  output logic      [NUM_LINES-1:0]    tx_allow,
  output logic      [NUM_LINES-1:0]    tx_two_stop,
  output logic      [NUM_LINES-1:0]    rx_two_stop,
  output logic      [NUM_LINES-1:0]    loopback,
  output logic      [NUM_LINES-1:0]    dsr_separate,
  output logic      [8:0]              int_vector,
  output logic      [2:0]              emul_count
);

  typedef struct packed {
    mxc_state_t              state;
    logic                    primed;
    logic [1:0]              panels;
    logic                    flow_gate;
    logic                    stop2;
    logic                    loop;
    logic [NUM_LINES-1:0]    flow_en;
    logic [NUM_ADAPTERS-1:0] dsr_sel;
    logic [HOST_AW-1:0]      base;
    logic [8:0]              vector;
    logic                    hit;
    logic [2:0]              emul;
    logic [3:0]              regi;
    logic [NUM_LINES-1:0]    allow;
    logic [NUM_LINES-1:0]    two_stop;
    logic [NUM_LINES-1:0]    loop_out;
    logic [NUM_LINES-1:0]    dsr_out;
    logic [2:0]              emul_out;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    err;
  } mxc_regs_t;

  mxc_regs_t r;
  mxc_regs_t next_r;

  logic [HOST_AW-1:0]   rom_base;
  logic [NUM_LINES-1:0] dsr_lines;
  logic [NUM_LINES-1:0] flow_hold;
  logic                 apb_setup;
  logic                 apb_write;
  logic [2:0]           emuls;
  logic [HOST_AW-1:0]   span;
  logic [HOST_AW-1:0]   offs;
  logic [HOST_AW-1:0]   decode_end;
  logic                 in_range;

  // ---------------------------------------------------------------------------
  // Base table
  // ---------------------------------------------------------------------------
  mxc_base_rom u_rom (
    .mclk  (mclk),
    .rst   (rst),
    .index (base_address_switches),
    .base  (rom_base)
  );

  // ---------------------------------------------------------------------------
  // Per-adapter expansion of the DSR option
  // ---------------------------------------------------------------------------
  // Each adapter's option switch covers its eight lines as one group.
  genvar a;
  generate
    for (a = 0; a < NUM_ADAPTERS; a++) begin : g_adpt
      assign dsr_lines[a*LINES_PER_ADPT +: LINES_PER_ADPT] =
        {LINES_PER_ADPT{r.dsr_sel[a]}};
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Per-line transmit permission
  // ---------------------------------------------------------------------------
  // A line is held only when both switches enable flow control and its CTS is
  // low; a line without the option never waits on a CTS pin left open.
  genvar l;
  generate
    for (l = 0; l < NUM_LINES; l++) begin : g_line
      assign flow_hold[l] = r.flow_gate && r.flow_en[l] && !line_cts[l];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Bus phases and host decode helpers
  // ---------------------------------------------------------------------------
  // Writes land at the access edge, where the master sees pready high, so a
  // setup cycle that is abandoned leaves every register untouched.
  assign apb_setup  = psel && !penable;
  assign apb_write  = psel && penable && pwrite && r.ready;

  // The range test also rejects addresses below the base, where offs wraps.
  assign emuls      = {r.panels, 1'b0};
  assign span       = HOST_AW'(BLOCK_BYTES * emuls);
  assign offs       = HOST_AW'(host_addr - r.base);
  assign decode_end = HOST_AW'(r.base + span);
  assign in_range   = (host_addr >= r.base) && (offs < span);

  // ---------------------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------------------
  // The flow hold state is deliberately absent from what software can read.
  function automatic logic [31:0] config_word(input mxc_regs_t s, input logic [2:0] n);
    logic [31:0] w;
    w                     = READ_ZERO;
    w[CFG_FLOW_BIT]       = s.flow_gate;
    w[CFG_STOP2_BIT]      = s.stop2;
    w[CFG_LOOP_BIT]       = s.loop;
    w[CFG_VALID_BIT]      = (s.state == MXC_RUN);
    w[CFG_PANEL_LSB +: 2] = s.panels;
    w[CFG_EMUL_LSB +: 3]  = n;
    return w;
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r = r;

    // -------------------------------------------------------------------------
    // Switch capture
    // -------------------------------------------------------------------------
    // The table output lags its index by one clock, so a capture spends one
    // cycle priming it and takes every switch in the next.
    case (r.state)
      MXC_SAMPLE: begin
        next_r.primed = 1'b1;
        if (r.primed) begin
          next_r.state     = MXC_RUN;
          next_r.base      = rom_base;
          // A zero switch code is treated as one panel; three is the maximum.
          next_r.panels    = (panel_count_switches == 2'd0) ? 2'd1 :
                             panel_count_switches;
          next_r.flow_gate = global_flow_gate_switch;
          next_r.stop2     = force_double_stop_switch;
          next_r.loop      = force_loopback_switch;
          next_r.flow_en   = per_line_flow_enable_switches;
          next_r.dsr_sel   = independent_dsr_switch;
        end
      end
      MXC_RUN: begin
        next_r.state = MXC_RUN;
      end
      default: begin
        next_r.state  = MXC_SAMPLE;
        next_r.primed = 1'b0;
      end
    endcase

    // -------------------------------------------------------------------------
    // Host decode
    // -------------------------------------------------------------------------
    // Blocks of sixteen word registers, 32 bytes each, follow the base.
    next_r.hit  = host_strobe && (r.state == MXC_RUN) && in_range;
    next_r.emul = 3'(offs >> BLOCK_BYTES_LOG2);
    next_r.regi = offs[4:1];

    // -------------------------------------------------------------------------
    // Line controls
    // -------------------------------------------------------------------------
    // Flow holds only gate the transmitters; no register ever reports them.
    next_r.allow    = ~flow_hold;
    next_r.two_stop = {NUM_LINES{r.stop2}};
    next_r.loop_out = {NUM_LINES{r.loop}};
    next_r.dsr_out  = dsr_lines;
    next_r.emul_out = emuls;

    // -------------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------------
    // The answer is prepared in the setup cycle and stands for the single
    // access cycle; the bus reads zero at all other times.
    next_r.ready = apb_setup;
    next_r.err   = 1'b0;
    next_r.rdata = READ_ZERO;
    if (apb_setup) begin
      if (paddr == OFS_CTRL) begin
        next_r.rdata = READ_ZERO;
      end else if (paddr == OFS_VECTOR) begin
        next_r.rdata = {23'h0, r.vector};
      end else if (paddr == OFS_CONFIG) begin
        next_r.rdata = config_word(r, emuls);
      end else if (paddr == OFS_BASE) begin
        next_r.rdata = {14'h0, r.base};
      end else if (paddr == OFS_DECODE) begin
        next_r.rdata = {14'h0, decode_end};
      end else if (paddr == OFS_DSRMODE) begin
        next_r.rdata = {26'h0, r.dsr_sel};
      end else if (paddr == OFS_FLOWLO) begin
        next_r.rdata = r.flow_en[31:0];
      end else if (paddr == OFS_FLOWHI) begin
        next_r.rdata = {16'h0, r.flow_en[NUM_LINES-1:32]};
      end else begin
        // Unmapped offsets answer with an error and read as zero.
        next_r.err = 1'b1;
      end
    end

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    if (apb_write) begin
      if (paddr == OFS_CTRL) begin
        if (pwdata[CTRL_RESAMPLE_BIT]) begin
          // Capture restarts with the priming cycle in case the base switches
          // moved just before the request.
          next_r.state  = MXC_SAMPLE;
          next_r.primed = 1'b0;
        end
      end else if (paddr == OFS_VECTOR) begin
        next_r.vector = pwdata[8:0];
      end
      // Read-only and unmapped offsets ignore writes.
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset leaves every line free to transmit until the switches are captured.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r        <= '0;
      r.state  <= MXC_SAMPLE;
      r.panels <= 2'd1;
      r.vector <= VECTOR_RST;
      r.allow  <= '1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, each straight from a field of the state register
  // ---------------------------------------------------------------------------
  // One switch forces both directions, so both stop-bit outputs share a field.
  assign prdata       = r.rdata;
  assign pready       = r.ready;
  assign pslverr      = r.err;
  assign host_hit     = r.hit;
  assign host_emul    = r.emul;
  assign host_reg     = r.regi;
  assign tx_allow     = r.allow;
  assign tx_two_stop  = r.two_stop;
  assign rx_two_stop  = r.two_stop;
  assign loopback     = r.loop_out;
  assign dsr_separate = r.dsr_out;
  assign int_vector   = r.vector;
  assign emul_count   = r.emul_out;

endmodule

// ### design/mxc_pkg.sv
package mxc_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int         NUM_PANELS_MAX   = 3;
  localparam int         NUM_ADAPTERS     = 6;
  localparam int         LINES_PER_ADPT   = 8;
  localparam int         NUM_LINES        = 48;
  localparam int         EMUL_PER_PANEL   = 2;
  localparam int         HOST_AW          = 18;
  localparam logic [4:0] BLOCK_BYTES_LOG2 = 5'd5;
  localparam logic [17:0] BLOCK_BYTES     = 18'h00020;
  localparam logic [3:0] REG_IDX_MAX      = 4'hf;

  // ---------------------------------------------------------------------------
  // Base address lookup (replaceable table, 16 entries of 32-byte aligned bases)
  // ---------------------------------------------------------------------------
  localparam logic [17:0] BASE_TABLE_START = 18'h3e0e0;
  localparam logic [17:0] BASE_TABLE_STEP  = 18'h00020;

  // ---------------------------------------------------------------------------
  // APB register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_VECTOR  = 12'h004;
  localparam logic [11:0] OFS_CONFIG  = 12'h008;
  localparam logic [11:0] OFS_BASE    = 12'h00c;
  localparam logic [11:0] OFS_DECODE  = 12'h010;
  localparam logic [11:0] OFS_DSRMODE = 12'h014;
  localparam logic [11:0] OFS_FLOWLO  = 12'h018;
  localparam logic [11:0] OFS_FLOWHI  = 12'h01c;

  localparam logic [8:0]  VECTOR_RST  = 9'h000;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // CTRL: bit 0 = capture strobe, re-samples the switches on demand.
  localparam int CTRL_RESAMPLE_BIT = 0;
  // CONFIG fields.
  localparam int CFG_FLOW_BIT  = 0;
  localparam int CFG_STOP2_BIT = 1;
  localparam int CFG_LOOP_BIT  = 2;
  localparam int CFG_VALID_BIT = 3;
  localparam int CFG_PANEL_LSB = 4;
  localparam int CFG_EMUL_LSB  = 8;

  typedef enum logic [1:0] {
    MXC_SAMPLE,
    MXC_RUN
  } mxc_state_t;

endpackage

// ### design/mxc_base_rom.sv
`timescale 1ns/1ns
// Replaceable base-address table; the read value is registered.
module mxc_base_rom
  import mxc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [3:0]        index,
  output logic      [HOST_AW-1:0] base
);

  logic [HOST_AW-1:0] table_q [16];

  // ---------------------------------------------------------------------------
  // Table contents
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_entry
      assign table_q[g] = HOST_AW'(BASE_TABLE_START + BASE_TABLE_STEP * g);
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base <= '0;
    end else begin
      base <= table_q[index];
    end
  end

endmodule

// ### sim/mxc_line_model.sv
`timescale 1ns/1ns
module mxc_line_model
  import mxc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic [NUM_LINES-1:0] want,
  output logic      [NUM_LINES-1:0] line_cts
);
  // One register stands in for the cable, so CTS never moves in step with the bench.
  always_ff @(posedge mclk) begin
    line_cts <= want;
  end
endmodule

// ### sim/mxc_config_properties.sv
`timescale 1ns/1ns
module mxc_config_properties
  import mxc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic                 pready,
  input  wire logic                 pslverr,
  input  wire logic [NUM_LINES-1:0] line_cts,
  input  wire logic                 host_hit,
  input  wire logic [2:0]           host_emul,
  input  wire logic [NUM_LINES-1:0] tx_allow,
  input  wire logic [NUM_LINES-1:0] tx_two_stop,
  input  wire logic [NUM_LINES-1:0] rx_two_stop,
  input  wire logic [NUM_LINES-1:0] loopback,
  input  wire logic [8:0]           int_vector,
  input  wire logic [2:0]           emul_count
);
  logic [1:0] cnt;
  logic       settled;
  // Derived outputs are only meaningful once the switch capture has landed.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
    end else if (cnt != 2'h3) begin
      cnt <= cnt + 2'h1;
    end
  end
  assign settled = (cnt == 2'h3);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_ready: assert property (pslverr |-> pready && !$past(pready))
    else $error("error without single ready");
  chk_vector_store: assert property (psel && penable && pready && pwrite
    && paddr == OFS_VECTOR |=> int_vector == $past(pwdata[8:0]))
    else $error("vector not stored");
  chk_emul_twice: assert property (settled |-> emul_count inside {3'h2, 3'h4, 3'h6})
    else $error("emulation count not twice panels");
  chk_stop_both: assert property (settled |-> tx_two_stop == rx_two_stop
    && (tx_two_stop == '0 || &tx_two_stop))
    else $error("stop bit forcing not uniform");
  chk_loop_all: assert property (settled |-> loopback == '0 || &loopback)
    else $error("loopback not uniform");
  chk_cts_allow: assert property (settled |-> (tx_allow | ~$past(line_cts)) == '1)
    else $error("line held with cts asserted");
  chk_hit_range: assert property (host_hit |-> host_emul < emul_count)
    else $error("hit beyond decoded emulations");
endmodule
bind mxc_config mxc_config_properties mxc_config_properties_inst (.*);

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import mxc_pkg::*;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        gate = 0, stop2 = 0, loop = 0, strobe = 0, host_hit;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  bsw = 0, host_reg;
  logic [1:0]  psw = 0;
  logic [5:0]  dsr = 0;
  logic [17:0] haddr = 0;
  logic [2:0]  host_emul, emul_count;
  logic [8:0]  int_vector;
  logic [47:0] fen = 0, want = 0, cts, tx_allow, tx2, rx2, lpb, dsep;
  int          n_mismatch = 0, n_tests = 0;
  mxc_line_model mxc_line_model_inst (.mclk(mclk), .want(want), .line_cts(cts));
  mxc_config mxc_config_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .base_address_switches(bsw), .panel_count_switches(psw),
    .global_flow_gate_switch(gate), .force_double_stop_switch(stop2),
    .force_loopback_switch(loop), .per_line_flow_enable_switches(fen),
    .independent_dsr_switch(dsr), .host_addr(haddr), .host_strobe(strobe), .line_cts(cts),
    .host_hit(host_hit), .host_emul(host_emul), .host_reg(host_reg), .tx_allow(tx_allow),
    .tx_two_stop(tx2), .rx_two_stop(rx2), .loopback(lpb), .dsr_separate(dsep),
    .int_vector(int_vector), .emul_count(emul_count));
  initial forever #2 mclk = ~mclk;
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic resample;
    logic [31:0] q;
    logic        e;
    apb(1, OFS_CTRL, 32'h1, q, e);
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_apb;
    logic [31:0] q;
    logic        e;
    apb(1, OFS_VECTOR, 32'hffff_f1a5, q, e);
    check(int_vector, 9'h1a5);
    apb(0, OFS_VECTOR, 0, q, e);
    check({e, q[8:0]}, {1'b0, 9'h1a5});
    apb(1, 12'h100, 32'h0, q, e);
    check({e, q}, {1'b1, 32'h0});
  endtask
  task automatic t_panels;
    logic [17:0] base;
    int          np;
    logic [31:0] q;
    logic        e;
    for (int c = 0; c < 4; c++) begin
      bsw <= 4'(c * 5);
      psw <= 2'(c);
      resample();
      np = (c == 0) ? 1 : c;
      base = BASE_TABLE_START + 18'(32 * c * 5);
      check(emul_count, 2 * np);
      apb(0, OFS_BASE, 0, q, e);
      check({e, q}, {1'b0, 14'h0, base});
      apb(0, OFS_DECODE, 0, q, e);
      check(q, base + 18'(64 * np));
      apb(0, OFS_CONFIG, 0, q, e);
      check({q[CFG_EMUL_LSB +: 3], q[CFG_PANEL_LSB +: 2]}, {3'(2 * np), 2'(np)});
      haddr <= base + 18'(32 * (2 * np - 1) + 10);
      strobe <= 1;
      repeat (2) @(posedge mclk);
      check({host_hit, host_emul, host_reg}, {1'b1, 3'(2 * np - 1), 4'h5});
      haddr <= base + 18'(64 * np);
      repeat (2) @(posedge mclk);
      check(host_hit, 0);
      strobe <= 0;
      @(posedge mclk);
    end
  endtask
  task automatic t_options;
    logic [47:0] exp;
    gate <= 1;
    stop2 <= 1;
    loop <= 1;
    dsr <= 6'h25;
    fen <= 48'h00ff_0f0f_33f0;
    want <= 48'h0f0f_00ff_5555;
    resample();
    for (int i = 0; i < 48; i++) exp[i] = dsr[i / 8];
    check(dsep, exp);
    check(tx_allow, 48'(~fen | want));
    check({tx2, rx2, lpb}, {144{1'b1}});
    gate <= 0;
    stop2 <= 0;
    repeat (4) @(posedge mclk);
    check(tx2, {48{1'b1}});
    resample();
    check(tx_allow, {48{1'b1}});
    check(rx2, 0);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    repeat (3) @(posedge mclk);
    t_apb();
    t_panels();
    t_options();
    report_and_stop();
  end
endmodule
